// ### hw/cdr_limits_defines.vh
// Constants for the recovery limit and supply status register block.
`ifndef CDR_LIMITS_DEFINES_VH
`define CDR_LIMITS_DEFINES_VH

// Register addresses (7-bit).
`define ADDR_CDR_CTRL2 7'h3d
`define ADDR_UPPER_LIMIT 7'h3e
`define ADDR_LOWER_LIMIT 7'h3f
`define ADDR_SUPPLY_STAT1 7'h40

// Reset values.
`define RST_UPPER_LIMIT 8'ha8
`define RST_LOWER_LIMIT 8'h98
`define RST_CLK_SEL 2'h0
`define RST_STATUS 8'h00

// Frame layout.
`define FRAME_BITS 5'h10
`define MODE_BIT 7
`define LAST_BIT_COUNT 5'h0f
`define CMD_LAST_BIT 5'h07

// Supply status bit positions.
`define STAT_RESERVED_MASK 8'hdf
`define BIT_IO_WARN 0

// Mode codes.
`define MODE_INIT 3'h0
`define MODE_NORMAL 3'h1
`define MODE_STOP 3'h2
`define MODE_SLEEP 3'h3
`define MODE_RESTART 3'h4

// Recovery clock select codes and their divide ratios from the 80 MHz source.
`define CLK_SEL_80 2'h0
`define CLK_SEL_40 2'h1
`define CLK_SEL_20 2'h2
`define CLK_SEL_10 2'h3
`define DIV_W 3

`endif

// ### hw/recovery_clock_divider.v
// Enable-pulse divider giving the recovery clock rate from the oscillator.
`timescale 1ns/1ps
`include "cdr_limits_defines.vh"

module recovery_clock_divider (
    // Clock and reset.
    input wire clock_i,
    input wire reset_i,
    // Select code.
    input wire [1:0] sel_i,
    // One-cycle tick at the selected rate.
    output reg tick_o
);
    // Free running counter.
    reg [`DIV_W-1:0] count_reg;
    // Terminal count for the selected division.
    reg [`DIV_W-1:0] limit;

    // Code 00 ticks every cycle, then 1/2, 1/4, 1/8 of it.
    always @* begin
        case (sel_i)
            `CLK_SEL_80: limit = 3'h0;
            `CLK_SEL_40: limit = 3'h1;
            `CLK_SEL_20: limit = 3'h3;
            default: limit = 3'h7;
        endcase
    end

    // Count and pulse at the limit.
    always @(posedge clock_i) begin
        if (reset_i) begin
            count_reg <= 3'h0;
            tick_o <= 1'b0;
        end else if (count_reg >= limit) begin
            count_reg <= 3'h0;
            tick_o <= 1'b1;
        end else begin
            count_reg <= count_reg + 3'h1;
            tick_o <= 1'b0;
        end
    end
endmodule // recovery_clock_divider

// ### hw/cdr_limits_and_supply_status.v
// Register bank slice: recovery clock select, bit-time limits, supply status one.
`timescale 1ns/1ps
`include "cdr_limits_defines.vh"

module cdr_limits_and_supply_status (
    // Clock and reset.
    input wire clock_i,
    input wire reset_i,
    // Serial link pins from the host.
    input wire spi_clk_i,
    input wire spi_cs_n_i,
    input wire spi_mosi_i,
    output reg spi_miso_o,
    // Supply detection events, one bit each.
    input wire boost_sense_low_voltage_i,
    input wire battery_undervoltage_i,
    input wire ext_supply_overcurrent_i,
    input wire ext_supply_undervoltage_i,
    input wire ext_supply_overtemperature_i,
    input wire io_supply_overvoltage_i,
    input wire io_supply_prewarning_i,
    input wire io_supply_short_i,
    // Device mode and reset output state.
    input wire [2:0] device_mode_i,
    input wire reset_output_n_i,
    // Recovered bit time from the measurement unit.
    input wire [7:0] measured_bit_time_i,
    input wire measure_valid_i,
    input wire frame_start_i,
    // Recovery outputs.
    output reg [7:0] clamped_bit_time_o,
    output reg clamped_valid_o,
    output reg recovery_tick_o,
    output reg [1:0] clock_select_o
);
    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    // First and second stages for serial clock, select and data.
    reg [2:0] pin_meta_reg;
    reg [2:0] pin_sync_reg;
    // Previous synchronised serial clock, for edge finding.
    reg sclk_prev_reg;
    // Two stages for the asynchronous supply events other than the IO short.
    reg [7:0] evt_meta_reg;
    reg [7:0] evt_sync_reg;

    // Only the second stages are read by logic.
    always @(posedge clock_i) begin
        if (reset_i) begin
            pin_meta_reg <= 3'h1;
            pin_sync_reg <= 3'h1;
            sclk_prev_reg <= 1'b0;
            evt_meta_reg <= `RST_STATUS;
            evt_sync_reg <= `RST_STATUS;
        end else begin
            pin_meta_reg <= {spi_clk_i, spi_mosi_i, spi_cs_n_i};
            pin_sync_reg <= pin_meta_reg;
            sclk_prev_reg <= pin_sync_reg[2];
            evt_meta_reg <= {boost_sense_low_voltage_i, battery_undervoltage_i, 1'b0,
                ext_supply_overcurrent_i, ext_supply_undervoltage_i,
                ext_supply_overtemperature_i, io_supply_overvoltage_i,
                io_supply_prewarning_i};
            evt_sync_reg <= evt_meta_reg;
        end
    end

    // Decoded pin levels and edges.
    wire sclk_s = pin_sync_reg[2];
    wire mosi_s = pin_sync_reg[1];
    wire cs_n_s = pin_sync_reg[0];
    wire sclk_rise = sclk_s & ~sclk_prev_reg;
    wire sclk_fall = ~sclk_s & sclk_prev_reg;

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    // Upper and lower limit as written by software.
    reg [7:0] upper_limit_reg;
    reg [7:0] lower_limit_reg;
    // Limits in force for the frame being measured.
    reg [7:0] active_upper_reg;
    reg [7:0] active_lower_reg;
    // Recovery clock select field.
    reg [1:0] clk_sel_reg;
    // Supply fail status one.
    reg [7:0] supply_stat_reg;
    // Whether the reset output has released since power-up.
    reg reset_released_reg;

    // ------------------------------------------------------------------
    // Serial frame engine
    // ------------------------------------------------------------------
    // Shift register for received bits, count and answer byte.
    reg [15:0] rx_shift_reg;
    reg [4:0] bit_count_reg;
    reg [7:0] tx_shift_reg;
    // Captured command: address and mode bit.
    reg [6:0] cmd_addr_reg;
    reg cmd_clear_reg;
    // One-cycle strobe when a full frame has ended.
    reg frame_done_reg;
    // Frame-level states, one-hot.
    localparam ST_IDLE = 3'b001;
    localparam ST_CMD = 3'b010;
    localparam ST_DATA = 3'b100;
    reg [2:0] state_reg;

    // Read-back value of the register at an address.
    function [7:0] read_value;
        input [6:0] addr;
        input [1:0] sel;
        input [7:0] up;
        input [7:0] lo;
        input [7:0] stat;
        begin
            if (addr == `ADDR_CDR_CTRL2) begin
                read_value = {6'h00, sel};
            end else if (addr == `ADDR_UPPER_LIMIT) begin
                read_value = up;
            end else if (addr == `ADDR_LOWER_LIMIT) begin
                read_value = lo;
            end else if (addr == `ADDR_SUPPLY_STAT1) begin
                read_value = stat & `STAT_RESERVED_MASK;
            end else begin
                read_value = 8'h00;
            end
        end
    endfunction

    // Frame bits arrive MSB-first as bits 15..0 of the word; the first byte holds
    // the address and mode, the second the data byte (frame bits 8..15 = D0..D7).
    always @(posedge clock_i) begin
        if (reset_i) begin
            state_reg <= ST_IDLE;
            rx_shift_reg <= 16'h0000;
            bit_count_reg <= 5'h00;
            tx_shift_reg <= 8'h00;
            cmd_addr_reg <= 7'h00;
            cmd_clear_reg <= 1'b0;
            frame_done_reg <= 1'b0;
            spi_miso_o <= 1'b0;
        end else begin
            frame_done_reg <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    // Wait for the host to select the device.
                    bit_count_reg <= 5'h00;
                    if (!cs_n_s) begin
                        state_reg <= ST_CMD;
                    end
                end
                ST_CMD, ST_DATA: begin
                    if (cs_n_s) begin
                        // Frame ends; act only on exactly sixteen bits.
                        state_reg <= ST_IDLE;
                        frame_done_reg <= (bit_count_reg == `FRAME_BITS);
                        // A cut frame must not leave the data line standing high.
                        spi_miso_o <= 1'b0;
                    end else if (sclk_rise) begin
                        rx_shift_reg <= {rx_shift_reg[14:0], mosi_s};
                        // Count one past sixteen so that a longer frame is refused too.
                        if (bit_count_reg <= `FRAME_BITS) begin
                            bit_count_reg <= bit_count_reg + 5'h01;
                        end
                        if (bit_count_reg == `CMD_LAST_BIT) begin
                            // Command byte complete: latch address, mode and answer.
                            cmd_addr_reg <= rx_shift_reg[6:0];
                            cmd_clear_reg <= mosi_s;
                            tx_shift_reg <= read_value(rx_shift_reg[6:0], clk_sel_reg,
                                upper_limit_reg, lower_limit_reg, supply_stat_reg);
                            state_reg <= ST_DATA;
                        end
                    end else if (sclk_fall && state_reg == ST_DATA) begin
                        // Shift out the data byte with D0 first at frame bit 8.
                        spi_miso_o <= tx_shift_reg[0];
                        tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Received data byte with D0 at the earliest data bit.
    wire [7:0] rx_data;
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_bitmap
            assign rx_data[gi] = rx_shift_reg[7 - gi];
        end
    endgenerate

    // A write to a control register uses mode one; status registers ignore data.
    wire do_write = frame_done_reg & cmd_clear_reg;
    wire do_clear = frame_done_reg & cmd_clear_reg & (cmd_addr_reg == `ADDR_SUPPLY_STAT1);

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    // Software writes limits and clock select.
    always @(posedge clock_i) begin
        if (reset_i) begin
            upper_limit_reg <= `RST_UPPER_LIMIT;
            lower_limit_reg <= `RST_LOWER_LIMIT;
            clk_sel_reg <= `RST_CLK_SEL;
        end else if (do_write) begin
            if (cmd_addr_reg == `ADDR_CDR_CTRL2) begin
                clk_sel_reg <= rx_data[1:0];
            end else if (cmd_addr_reg == `ADDR_UPPER_LIMIT) begin
                upper_limit_reg <= rx_data;
            end else if (cmd_addr_reg == `ADDR_LOWER_LIMIT) begin
                lower_limit_reg <= rx_data;
            end
        end
    end

    // Limits move into force only at the start of a recovered frame.
    always @(posedge clock_i) begin
        if (reset_i) begin
            active_upper_reg <= `RST_UPPER_LIMIT;
            active_lower_reg <= `RST_LOWER_LIMIT;
        end else if (frame_start_i) begin
            active_upper_reg <= upper_limit_reg;
            active_lower_reg <= lower_limit_reg;
        end
    end

    // ------------------------------------------------------------------
    // Bit-time clamp
    // ------------------------------------------------------------------
    // Out-of-range measurements are pulled to the nearest limit.
    always @(posedge clock_i) begin
        if (reset_i) begin
            clamped_bit_time_o <= 8'h00;
            clamped_valid_o <= 1'b0;
        end else begin
            clamped_valid_o <= measure_valid_i;
            if (measure_valid_i) begin
                if (measured_bit_time_i > active_upper_reg) begin
                    clamped_bit_time_o <= active_upper_reg;
                end else if (measured_bit_time_i < active_lower_reg) begin
                    clamped_bit_time_o <= active_lower_reg;
                end else begin
                    clamped_bit_time_o <= measured_bit_time_i;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Recovery clock rate
    // ------------------------------------------------------------------
    wire div_tick;

    recovery_clock_divider u_divider (
        .clock_i(clock_i),
        .reset_i(reset_i),
        .sel_i(clk_sel_reg),
        .tick_o(div_tick)
    );

    // Register the tick and select for clean outputs.
    always @(posedge clock_i) begin
        if (reset_i) begin
            recovery_tick_o <= 1'b0;
            clock_select_o <= `RST_CLK_SEL;
        end else begin
            recovery_tick_o <= div_tick;
            clock_select_o <= clk_sel_reg;
        end
    end

    // ------------------------------------------------------------------
    // Supply fail status one
    // ------------------------------------------------------------------
    // Tracks the first release of the reset output.
    always @(posedge clock_i) begin
        if (reset_i) begin
            reset_released_reg <= 1'b0;
        end else if (reset_output_n_i) begin
            reset_released_reg <= 1'b1;
        end
    end

    // Prewarning may update only in permitted modes or during an IO short.
    reg warn_allowed;
    always @* begin
        warn_allowed = 1'b0;
        if (io_supply_short_i) begin
            warn_allowed = 1'b1;
        end else if (device_mode_i == `MODE_NORMAL || device_mode_i == `MODE_STOP) begin
            warn_allowed = 1'b1;
        end else if (device_mode_i == `MODE_INIT) begin
            warn_allowed = reset_released_reg;
        end
    end

    // Only the prewarning event gated; reserved bit never set.
    wire [7:0] set_mask = (evt_sync_reg & `STAT_RESERVED_MASK
        & ~(8'h01 << `BIT_IO_WARN)) | ({7'h00, warn_allowed} & evt_sync_reg);

    // Bits latch; a clear drops them, but a same-cycle event wins.
    always @(posedge clock_i) begin
        if (reset_i) begin
            supply_stat_reg <= `RST_STATUS;
        end else if (do_clear) begin
            supply_stat_reg <= set_mask;
        end else begin
            supply_stat_reg <= supply_stat_reg | set_mask;
        end
    end
endmodule // cdr_limits_and_supply_status

// ### testbench/cdr_limits_and_supply_status_properties.sv
// Concurrent checks on the ports of the recovery limit and supply status block.
`timescale 1ns/1ps
module cdr_limits_checker (
    // Clock and reset.
    input wire logic clock_i,
    input wire logic reset_i,
    // Serial link.
    input wire logic spi_clk_i,
    input wire logic spi_cs_n_i,
    input wire logic spi_miso_o,
    // Recovery side.
    input wire logic measure_valid_i,
    input wire logic clamped_valid_o,
    input wire logic recovery_tick_o,
    input wire logic [1:0] clock_select_o
);
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (reset_i);
    // Cycles since the last tick; steady marks a select unchanged since that tick.
    logic [3:0] gap_reg;
    logic [1:0] sel_prev_reg;
    logic steady_reg;
    // Tracks tick spacing so that a wrong divide ratio shows as a wrong gap.
    always @(posedge clock_i) begin
        sel_prev_reg <= clock_select_o;
        if (reset_i) begin
            gap_reg <= 4'h0;
            steady_reg <= 1'b0;
        end else begin
            gap_reg <= recovery_tick_o ? 4'h0 : gap_reg + 4'h1;
            if (clock_select_o != sel_prev_reg) begin
                steady_reg <= 1'b0;
            end else if (recovery_tick_o) begin
                steady_reg <= 1'b1;
            end
        end
    end
    // The device has been deselected for a while.
    sequence s_link_idle;
        spi_cs_n_i [*6];
    endsequence
    // The link clock has stood high within a frame.
    sequence s_clock_high;
        (!spi_cs_n_i && spi_clk_i) [*5];
    endsequence
    a_tick_period: assert property (recovery_tick_o && steady_reg && clock_select_o == sel_prev_reg
        |-> gap_reg == (4'h1 << clock_select_o) - 4'h1) else $error("tick spacing wrong");
    a_tick_bound: assert property (steady_reg |-> gap_reg < 4'h8) else $error("tick missing");
    a_clamp_follows: assert property (measure_valid_i |=> clamped_valid_o)
        else $error("clamped result missing");
    a_clamp_cause: assert property (clamped_valid_o |-> $past(measure_valid_i))
        else $error("clamped result without measurement");
    a_miso_idle: assert property (s_link_idle |-> !spi_miso_o)
        else $error("data out active while deselected");
    a_miso_steady: assert property (s_clock_high |-> $stable(spi_miso_o))
        else $error("data out moved while clock high");
    a_select_framed: assert property ($changed(clock_select_o) |-> spi_cs_n_i && $past(spi_cs_n_i, 2))
        else $error("select changed inside a frame");
    a_select_reset: assert property ($fell(reset_i) |-> clock_select_o == 2'h0)
        else $error("select not zero after reset");
endmodule // cdr_limits_checker

bind cdr_limits_and_supply_status cdr_limits_checker checker_u (.clock_i(clock_i),
    .reset_i(reset_i), .spi_clk_i(spi_clk_i), .spi_cs_n_i(spi_cs_n_i), .spi_miso_o(spi_miso_o),
    .measure_valid_i(measure_valid_i), .clamped_valid_o(clamped_valid_o),
    .recovery_tick_o(recovery_tick_o), .clock_select_o(clock_select_o));

// ### testbench/spi_host_model.sv
// Host controller model that sends whole frames on the serial link.
`timescale 1ns/1ps
module spi_host_model (
    // Bench clock.
    input wire logic clock_i,
    // Serial link towards the device.
    output logic spi_clk_o,
    output logic spi_cs_n_o,
    output logic spi_mosi_o,
    input wire logic spi_miso_i
);
    // The link idles with its clock low and the device deselected.
    initial begin
        spi_clk_o = 1'b0;
        spi_cs_n_o = 1'b1;
        spi_mosi_o = 1'b0;
    end
    // One frame: address, access mode, then data with its low bit first.
    task automatic xfer(input logic [6:0] addr, input logic mode, input logic [7:0] data,
                        output logic [7:0] rdata);
        logic [15:0] word;
        word = {addr, mode, data[0], data[1], data[2], data[3],
                data[4], data[5], data[6], data[7]};
        rdata = 8'h00;
        @(posedge clock_i);
        spi_cs_n_o <= 1'b0;
        // Each phase lasts 5 clocks, so the clock period is 80 ns.
        for (int i = 15; i >= 0; i--) begin
            repeat (5) @(posedge clock_i);
            spi_clk_o <= 1'b0;
            spi_mosi_o <= word[i];
            repeat (5) @(posedge clock_i);
            spi_clk_o <= 1'b1;
            if (i < 8) begin
                rdata[7 - i] = spi_miso_i;
            end
        end
        repeat (5) @(posedge clock_i);
        spi_clk_o <= 1'b0;
        repeat (5) @(posedge clock_i);
        spi_cs_n_o <= 1'b1;
        // A released data line must not keep showing the last bit.
        spi_mosi_o <= ~word[0];
        repeat (6) @(posedge clock_i);
    endtask
endmodule // spi_host_model

// ### testbench/cdr_limits_and_supply_status_bench.sv
// Self-checking bench for the recovery limit and supply status block.
`timescale 1ns/1ps
`include "cdr_limits_defines.vh"
module cdr_limits_and_supply_status_bench;
    // Clock, reset and counters.
    logic clock_i = 1'b0;
    logic reset_i = 1'b1;
    int mismatches = 0;
    int total_checks = 0;
    // Stimulus; bit positions of ev follow the status byte.
    logic [7:0] ev = 8'h00;
    logic io_short = 1'b0;
    logic [2:0] mode = `MODE_NORMAL;
    logic rst_out_n = 1'b0;
    logic [7:0] measured = 8'h00;
    logic meas_valid = 1'b0;
    logic frame_start = 1'b0;
    // Link wires and observed outputs.
    logic sclk, cs_n, mosi, miso, clamped_valid, tick;
    logic [7:0] clamped, rdata;
    logic [1:0] sel;
    // Prewarning cases: mode, short, reset released, expected flag.
    logic [2:0] pw_mode [7] = '{`MODE_INIT, `MODE_RESTART, `MODE_SLEEP, `MODE_SLEEP,
                                `MODE_NORMAL, `MODE_STOP, `MODE_INIT};
    logic [6:0] pw_short = 7'b0001000;
    logic [6:0] pw_reset_output_n = 7'b1000000;
    logic [6:0] pw_expect = 7'b1111000;
    always #4 clock_i = ~clock_i;
    cdr_limits_and_supply_status dut (.clock_i(clock_i), .reset_i(reset_i), .spi_clk_i(sclk),
        .spi_cs_n_i(cs_n), .spi_mosi_i(mosi), .spi_miso_o(miso),
        .boost_sense_low_voltage_i(ev[7]), .battery_undervoltage_i(ev[6]),
        .ext_supply_overcurrent_i(ev[4]), .ext_supply_undervoltage_i(ev[3]),
        .ext_supply_overtemperature_i(ev[2]), .io_supply_overvoltage_i(ev[1]),
        .io_supply_prewarning_i(ev[0]), .io_supply_short_i(io_short), .device_mode_i(mode),
        .reset_output_n_i(rst_out_n), .measured_bit_time_i(measured),
        .measure_valid_i(meas_valid), .frame_start_i(frame_start),
        .clamped_bit_time_o(clamped), .clamped_valid_o(clamped_valid),
        .recovery_tick_o(tick), .clock_select_o(sel));
    spi_host_model host (.clock_i(clock_i), .spi_clk_o(sclk), .spi_cs_n_o(cs_n),
        .spi_mosi_o(mosi), .spi_miso_i(miso));
    // Compares one value and reports a difference at once.
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Register read, write or clear through whole frames.
    task automatic rd(input logic [6:0] addr, input logic [7:0] exp, input string what);
        host.xfer(addr, 1'b0, 8'h00, rdata);
        check(what, exp, rdata);
    endtask
    task automatic wr(input logic [6:0] addr, input logic [7:0] data);
        host.xfer(addr, 1'b1, data, rdata);
    endtask
    // One measurement; the result is looked at one cycle later.
    task automatic clamp(input logic [7:0] value, input logic [7:0] exp);
        @(posedge clock_i);
        measured <= value;
        meas_valid <= 1'b1;
        @(posedge clock_i);
        meas_valid <= 1'b0;
        @(posedge clock_i);
        check("clamped bit time", exp, clamped);
        check("clamped valid", 8'h01, {7'h00, clamped_valid});
    endtask
    task automatic wait_cycles(input int n);
        repeat (n) @(posedge clock_i);
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Cuts a hang short well beyond the expected run length.
    initial begin
        wait_cycles(30000);
        mismatches++;
        tally_and_finish();
    end
    initial begin
        wait_cycles(5);
        reset_i <= 1'b0;
        wait_cycles(4);
        rd(`ADDR_UPPER_LIMIT, `RST_UPPER_LIMIT, "upper limit reset");
        rd(`ADDR_LOWER_LIMIT, `RST_LOWER_LIMIT, "lower limit reset");
        rd(`ADDR_CDR_CTRL2, 8'h00, "select reset");
        rd(`ADDR_SUPPLY_STAT1, `RST_STATUS, "status reset");
        rd(7'h10, 8'h00, "unmapped");
        // Every select code, written with the upper bits set.
        for (int s = 0; s < 4; s++) begin
            wr(`ADDR_CDR_CTRL2, {6'h3f, s[1:0]});
            rd(`ADDR_CDR_CTRL2, {6'h00, s[1:0]}, "select field");
            check("select output", {6'h00, s[1:0]}, {6'h00, sel});
        end
        // The recommended row for the 40 MHz clock at the fastest baud rate.
        wr(`ADDR_CDR_CTRL2, 8'h01);
        wr(`ADDR_UPPER_LIMIT, 8'h54);
        wr(`ADDR_LOWER_LIMIT, 8'h4c);
        rd(`ADDR_UPPER_LIMIT, 8'h54, "upper limit");
        rd(`ADDR_LOWER_LIMIT, 8'h4c, "lower limit");
        // Old limits stay in force until the next frame starts.
        clamp(8'hb0, `RST_UPPER_LIMIT);
        clamp(8'h10, `RST_LOWER_LIMIT);
        frame_start <= 1'b1;
        wait_cycles(1);
        frame_start <= 1'b0;
        clamp(8'h60, 8'h54);
        clamp(8'h55, 8'h54);
        clamp(8'h54, 8'h54);
        clamp(8'h4b, 8'h4c);
        clamp(8'h4c, 8'h4c);
        clamp(8'h50, 8'h50);
        // The prewarning flag across modes and the short condition.
        for (int i = 0; i < 7; i++) begin
            mode <= pw_mode[i];
            io_short <= pw_short[i];
            rst_out_n <= pw_reset_output_n[i];
            wait_cycles(4);
            ev <= 8'h01;
            wait_cycles(6);
            ev <= 8'h00;
            wait_cycles(6);
            rd(`ADDR_SUPPLY_STAT1, {7'h00, pw_expect[i]}, "prewarning");
            wr(`ADDR_SUPPLY_STAT1, 8'hff);
        end
        mode <= `MODE_NORMAL;
        io_short <= 1'b0;
        // Each flag but the prewarning alone: latched, returned by the clear, then gone.
        for (int b = 1; b < 8; b++) begin
            if (b != 5) begin
                ev <= 8'h01 << b;
                wait_cycles(6);
                ev <= 8'h00;
                wait_cycles(6);
                rd(`ADDR_SUPPLY_STAT1, 8'h01 << b, "latched flag");
                host.xfer(`ADDR_SUPPLY_STAT1, 1'b1, 8'h00, rdata);
                check("clear result", 8'h01 << b, rdata);
                rd(`ADDR_SUPPLY_STAT1, 8'h00, "cleared flag");
            end
        end
        // All flags, with one event still present across the clear.
        ev <= 8'hff;
        wait_cycles(6);
        ev <= 8'h40;
        wait_cycles(6);
        rd(`ADDR_SUPPLY_STAT1, 8'hdf, "all flags");
        rd(`ADDR_SUPPLY_STAT1, 8'hdf, "all flags again");
        host.xfer(`ADDR_SUPPLY_STAT1, 1'b1, 8'hff, rdata);
        check("clear result", 8'hdf, rdata);
        rd(`ADDR_SUPPLY_STAT1, 8'h40, "event over clear");
        ev <= 8'h00;
        wait_cycles(6);
        wr(`ADDR_SUPPLY_STAT1, 8'hff);
        rd(`ADDR_SUPPLY_STAT1, 8'h00, "all cleared");
        tally_and_finish();
    end
endmodule // cdr_limits_and_supply_status_bench
